// ===== rtl/pin_mux_params.svh
// constants for the port pin function multiplexer
// assumes inclusion by the design file only; definitions only
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH

// combined pin vector: port a pins 0..7, port b pin 0 as index 8
`define NPIN      9
`define PA_DBG    0
`define PA_SYNC   1
`define PA_T0     2
`define PA_ANMAX  3
`define PA_NONE   4
`define PA_MASTER_CLEAR_INPUT   5
`define PA_CCD    6
`define PA_SCL    7
`define PB_SDA    8

// master/slave field codes
`define MS_ALONE  2'h0
`define MS_MASTER 2'h1
`define MS_SLAVE  2'h2

// reset values: pins idle high, master clear released
`define FILT_RST  9'h1FF
`define ZERO9     9'h000
`define ZERO4     4'h0

`endif

// ===== rtl/pin_mux_pkg.sv
// types shared by the port pin function multiplexer
// assumes nothing of its surroundings
package pin_mux_pkg;
  typedef logic [1:0] ms_mode_t;
  typedef logic [8:0] pin_vec_t;
endpackage : pin_mux_pkg

// ===== rtl/port_a_pin_function_mux.sv
// pin function multiplexer for port a pins 0..7 and port b pin 0
// assumes one clock, pins sampled asynchronously, pin wire resolved outside
`timescale 1ns/100ps
`include "pin_mux_params.svh"

module port_a_pin_function_mux #(
  parameter int DBG_W = 8,
  parameter int DSEL_W = 3,
  parameter int CHSEL_W = 4
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  ce,
  input  wire pin_mux_pkg::pin_vec_t pin_in,
  input  wire logic [7:0]            port_a_direction,
  input  wire logic                  port_b_direction,
  input  wire pin_mux_pkg::pin_vec_t pin_latch,
  input  wire logic [3:0]            analog_select_a,
  input  wire pin_mux_pkg::pin_vec_t pullup_request,
  input  wire pin_mux_pkg::pin_vec_t ioc_enable,
  input  wire logic                  debug_out_en,
  input  wire logic                  debug_analog_mode,
  input  wire logic [DSEL_W-1:0]     debug_digital_sel,
  input  wire logic [DBG_W-1:0]      debug_digital_bus,
  input  wire logic [CHSEL_W-1:0]    converter_control_0,
  input  wire pin_mux_pkg::ms_mode_t master_slave_field,
  input  wire logic                  sync_clk_out,
  input  wire logic                  timer0_source_select,
  input  wire logic                  external_interrupt_enable,
  input  wire logic                  master_clear_enable,
  input  wire logic                  compare_en,
  input  wire logic                  compare_out,
  input  wire logic                  prog_mode,
  input  wire logic                  prog_data_out,
  input  wire logic                  prog_data_oe,
  input  wire logic                  i2c_enable,
  input  wire logic                  scl_drive_low,
  input  wire logic                  sda_drive_low,
  output logic [8:0]                 pin_out_ff,
  output logic [8:0]                 pin_oe_ff,
  output logic [8:0]                 pullup_ff,
  output logic [8:0]                 ioc_pulse_ff,
  output logic [8:0]                 pin_level_ff,
  output logic [3:0]                 adc_connect_ff,
  output logic                       test_analog_on_ff,
  output logic [CHSEL_W-1:0]         test_analog_sel_ff,
  output logic                       sync_clk_in_ff,
  output logic                       ref2_out_en_ff,
  output logic                       t0_ext_clk_ff,
  output logic                       ext_int_ff,
  output logic                       master_clear_n_ff,
  output logic                       capture_in_ff,
  output logic                       prog_data_in_ff,
  output logic                       prog_clk_in_ff,
  output logic                       scl_in_ff,
  output logic                       sda_in_ff
);

  ////////////////////////////////////////////////////////////////////////
  // pin input synchronisers, three stages, agreement filter
  logic [8:0] s1_ff, s2_ff, s3_ff, filt_ff;
  logic [8:0] nxt_s1, nxt_s2, nxt_s3, nxt_filt;

  // shift and accept a level once stages two and three agree
  always_comb begin
    nxt_s1 = s1_ff;
    nxt_s2 = s2_ff;
    nxt_s3 = s3_ff;
    nxt_filt = filt_ff;
    if (ce) begin
      nxt_s1 = pin_in;
      nxt_s2 = s1_ff;
      nxt_s3 = s2_ff;
      for (int i = 0; i < `NPIN; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          nxt_filt[i] = s3_ff[i];
        end
      end
    end
  end

  // synchroniser registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= `FILT_RST;
      s2_ff <= `FILT_RST;
      s3_ff <= `FILT_RST;
      filt_ff <= `FILT_RST;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
      filt_ff <= nxt_filt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // function selection
  logic [8:0]         dir;
  logic [8:0]         nxt_out, nxt_oe, nxt_pull, nxt_ioc, nxt_level;
  logic [3:0]         nxt_adc;
  logic               nxt_tan, nxt_sync, nxt_ref2, nxt_t0, nxt_int, nxt_master_clear_input;
  logic               nxt_cap, nxt_pdat, nxt_pclk, nxt_scl, nxt_sda;
  logic [CHSEL_W-1:0] nxt_tsel;
  logic               is_master, is_slave;

  // direction bit set means input
  assign dir = {port_b_direction, port_a_direction};
  assign is_master = (master_slave_field == `MS_MASTER);
  assign is_slave = (master_slave_field == `MS_SLAVE);

  // next value of every output
  always_comb begin
    nxt_out = pin_out_ff;
    nxt_oe = pin_oe_ff;
    nxt_pull = pullup_ff;
    nxt_ioc = ioc_pulse_ff;
    nxt_level = pin_level_ff;
    nxt_adc = adc_connect_ff;
    nxt_tan = test_analog_on_ff;
    nxt_tsel = test_analog_sel_ff;
    nxt_sync = sync_clk_in_ff;
    nxt_ref2 = ref2_out_en_ff;
    nxt_t0 = t0_ext_clk_ff;
    nxt_int = ext_int_ff;
    nxt_master_clear_input = master_clear_n_ff;
    nxt_cap = capture_in_ff;
    nxt_pdat = prog_data_in_ff;
    nxt_pclk = prog_clk_in_ff;
    nxt_scl = scl_in_ff;
    nxt_sda = sda_in_ff;
    if (ce) begin
      // general purpose drive: output when direction bit clear
      nxt_out = pin_latch;
      nxt_oe = ~dir;
      nxt_level = nxt_filt;
      // weak pull-ups only where the pin is an input
      nxt_pull = pullup_request & dir;
      // change detect on the filtered level
      nxt_ioc = (nxt_filt ^ filt_ff) & ioc_enable;
      nxt_ioc[`PA_NONE] = 1'b0;
      nxt_ioc[`PA_CCD] = 1'b0;
      // analog channel switches need input and analog select
      nxt_adc = port_a_direction[`PA_ANMAX:0] & analog_select_a;
      // debug test output on pin 0
      nxt_tsel = converter_control_0;
      nxt_tan = debug_out_en & debug_analog_mode;
      if (debug_out_en) begin
        nxt_oe[`PA_DBG] = ~debug_analog_mode;
        nxt_out[`PA_DBG] = debug_digital_bus[debug_digital_sel];
      end
      // switching sync clock on pin 1
      nxt_sync = is_slave ? nxt_filt[`PA_SYNC] : 1'b0;
      if (is_master) begin
        nxt_oe[`PA_SYNC] = 1'b1;
        nxt_out[`PA_SYNC] = sync_clk_out;
      end else if (is_slave) begin
        nxt_oe[`PA_SYNC] = 1'b0;
      end
      nxt_ref2 = is_master;
      // timer0 clock and external interrupt on pin 2
      nxt_t0 = timer0_source_select & nxt_filt[`PA_T0];
      nxt_int = external_interrupt_enable & nxt_filt[`PA_T0];
      // pin 5 never drives; master clear when enabled
      nxt_oe[`PA_MASTER_CLEAR_INPUT] = 1'b0;
      nxt_out[`PA_MASTER_CLEAR_INPUT] = 1'b0;
      nxt_master_clear_input = master_clear_enable ? nxt_filt[`PA_MASTER_CLEAR_INPUT] : 1'b1;
      // pin 6: programming data over compare over port
      nxt_cap = nxt_filt[`PA_CCD];
      nxt_pdat = prog_mode & nxt_filt[`PA_CCD];
      if (prog_mode) begin
        nxt_oe[`PA_CCD] = prog_data_oe;
        nxt_out[`PA_CCD] = prog_data_out;
      end else if (compare_en) begin
        nxt_oe[`PA_CCD] = 1'b1;
        nxt_out[`PA_CCD] = compare_out;
      end
      // open drain pins only ever pull low, no pull-up
      nxt_pull[`PA_SCL] = 1'b0;
      nxt_pull[`PB_SDA] = 1'b0;
      nxt_out[`PA_SCL] = 1'b0;
      nxt_out[`PB_SDA] = 1'b0;
      nxt_oe[`PA_SCL] = ~dir[`PA_SCL] & ~pin_latch[`PA_SCL];
      nxt_oe[`PB_SDA] = ~dir[`PB_SDA] & ~pin_latch[`PB_SDA];
      nxt_pclk = nxt_filt[`PA_SCL];
      // i2c takes over the open drain drivers
      nxt_scl = i2c_enable & nxt_filt[`PA_SCL];
      nxt_sda = i2c_enable & nxt_filt[`PB_SDA];
      if (i2c_enable) begin
        nxt_oe[`PA_SCL] = scl_drive_low;
        nxt_oe[`PB_SDA] = sda_drive_low;
      end
      // pin 4 is not bonded in this block
      nxt_oe[`PA_NONE] = 1'b0;
      nxt_out[`PA_NONE] = 1'b0;
      nxt_pull[`PA_NONE] = 1'b0;
    end
  end

  // output registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_out_ff <= `ZERO9;
      pin_oe_ff <= `ZERO9;
      pullup_ff <= `ZERO9;
      ioc_pulse_ff <= `ZERO9;
      pin_level_ff <= `FILT_RST;
      adc_connect_ff <= `ZERO4;
      test_analog_on_ff <= 1'b0;
      test_analog_sel_ff <= '0;
      sync_clk_in_ff <= 1'b0;
      ref2_out_en_ff <= 1'b0;
      t0_ext_clk_ff <= 1'b0;
      ext_int_ff <= 1'b0;
      master_clear_n_ff <= 1'b1;
      capture_in_ff <= 1'b0;
      prog_data_in_ff <= 1'b0;
      prog_clk_in_ff <= 1'b0;
      scl_in_ff <= 1'b0;
      sda_in_ff <= 1'b0;
    end else begin
      pin_out_ff <= nxt_out;
      pin_oe_ff <= nxt_oe;
      pullup_ff <= nxt_pull;
      ioc_pulse_ff <= nxt_ioc;
      pin_level_ff <= nxt_level;
      adc_connect_ff <= nxt_adc;
      test_analog_on_ff <= nxt_tan;
      test_analog_sel_ff <= nxt_tsel;
      sync_clk_in_ff <= nxt_sync;
      ref2_out_en_ff <= nxt_ref2;
      t0_ext_clk_ff <= nxt_t0;
      ext_int_ff <= nxt_int;
      master_clear_n_ff <= nxt_master_clear_input;
      capture_in_ff <= nxt_cap;
      prog_data_in_ff <= nxt_pdat;
      prog_clk_in_ff <= nxt_pclk;
      scl_in_ff <= nxt_scl;
      sda_in_ff <= nxt_sda;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_pin5_input_only: assert property (!pin_oe_ff[`PA_MASTER_CLEAR_INPUT])
    else $error("pin 5 driven");
  a_od_no_high: assert property (!pin_out_ff[`PA_SCL] && !pin_out_ff[`PB_SDA]
    && !pullup_ff[`PA_SCL] && !pullup_ff[`PB_SDA]) else $error("open drain pin pulled high");
  a_adc_ch0_route: assert property (ce |=> adc_connect_ff[0] ==
    ($past(port_a_direction[0]) && $past(analog_select_a[0]))) else $error("channel 0 switch wrong");
  a_adc_ch1_route: assert property (ce |=> adc_connect_ff[1] ==
    ($past(port_a_direction[1]) && $past(analog_select_a[1]))) else $error("channel 1 switch wrong");
  a_adc_ch2_route: assert property (ce |=> adc_connect_ff[2] ==
    ($past(port_a_direction[2]) && $past(analog_select_a[2]))) else $error("channel 2 switch wrong");
  a_adc_ch3_route: assert property (ce |=> adc_connect_ff[3] ==
    ($past(port_a_direction[3]) && $past(analog_select_a[3]))) else $error("channel 3 switch wrong");
  a_debug_drive: assert property (ce && debug_out_en && !debug_analog_mode |=> pin_oe_ff[`PA_DBG])
    else $error("debug output not driven");
  a_sync_master_out: assert property (ce && is_master |=> pin_oe_ff[`PA_SYNC]
    && pin_out_ff[`PA_SYNC] == $past(sync_clk_out) && ref2_out_en_ff) else $error("master sync wrong");
  a_timer_clk_gate: assert property (ce && !timer0_source_select |=> !t0_ext_clk_ff)
    else $error("timer clock leaks");
  a_ext_int_gate: assert property (ce && !external_interrupt_enable |=> !ext_int_ff)
    else $error("interrupt leaks");
  a_master_clear_input_gate: assert property (ce && !master_clear_enable |=> master_clear_n_ff)
    else $error("master clear while disabled");
  a_scl_release: assert property (ce && i2c_enable |=> pin_oe_ff[`PA_SCL] == $past(scl_drive_low))
    else $error("scl drive wrong");
  a_sda_release: assert property (ce && i2c_enable |=> pin_oe_ff[`PB_SDA] == $past(sda_drive_low))
    else $error("sda drive wrong");

endmodule : port_a_pin_function_mux

// ===== testbench/board_model.sv
// board side of the pins: external drivers, pull-ups, floating lines
// assumes dut pin outputs are levels on clk
`timescale 1ns/100ps
module board_model (
  input  wire logic       clk,
  input  wire logic [8:0] pin_out,
  input  wire logic [8:0] pin_oe,
  input  wire logic [8:0] pull_on,
  input  wire logic [8:0] ext_en,
  input  wire logic [8:0] ext_val,
  output logic      [8:0] pin_in
);
  logic [8:0] last_ff = 9'h000;
  // floating lines show the inverse of their last level
  always_ff @(posedge clk) begin
    last_ff <= pin_in;
  end
  // dut driver, then board driver, then pull-up; i2c lines pulled up on the bus
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pull_on[i] || i >= 7) pin_in[i] = 1'b1;
      else pin_in[i] = ~last_ff[i];
    end
  end
endmodule : board_model

// ===== testbench/testbench.sv
// self-checking bench for the port pin function multiplexer
// assumes board_model resolves every pin wire
`timescale 1ns/100ps
module testbench;
  logic       clk = 1'b0, rstn = 1'b0, ce = 1'b1;
  logic [7:0] port_a_direction = 8'hFF, debug_digital_bus = 8'hA5;
  logic [8:0] pin_latch = 9'h000, pullup_request = 9'h1FF, ioc_enable = 9'h1FF, ext_en = 9'h000, ext_val = 9'h000;
  logic [3:0] analog_select_a = 4'h0, converter_control_0 = 4'h0;
  logic [2:0] debug_digital_sel = 3'h0;
  logic [1:0] master_slave_field = 2'h0;
  logic       port_b_direction = 1'b1, debug_out_en = 1'b0, debug_analog_mode = 1'b0, sync_clk_out = 1'b0;
  logic       timer0_source_select = 1'b0, external_interrupt_enable = 1'b0, master_clear_enable = 1'b0;
  logic       compare_en = 1'b0, compare_out = 1'b0, prog_mode = 1'b0, prog_data_out = 1'b0, prog_data_oe = 1'b0;
  logic       i2c_enable = 1'b0, scl_drive_low = 1'b0, sda_drive_low = 1'b0;
  logic [8:0] pin_in, pin_out_ff, pin_oe_ff, pullup_ff, ioc_pulse_ff, pin_level_ff;
  logic [3:0] adc_connect_ff, test_analog_sel_ff;
  logic       test_analog_on_ff, sync_clk_in_ff, ref2_out_en_ff, t0_ext_clk_ff, ext_int_ff, master_clear_n_ff;
  logic       capture_in_ff, prog_data_in_ff, prog_clk_in_ff, scl_in_ff, sda_in_ff;
  int         n_fail = 0, n_compared = 0, cycles = 0;

  port_a_pin_function_mux dut (.clk, .rstn, .ce, .pin_in, .port_a_direction, .port_b_direction, .pin_latch,
    .analog_select_a, .pullup_request, .ioc_enable, .debug_out_en, .debug_analog_mode, .debug_digital_sel,
    .debug_digital_bus, .converter_control_0, .master_slave_field, .sync_clk_out, .timer0_source_select,
    .external_interrupt_enable, .master_clear_enable, .compare_en, .compare_out, .prog_mode, .prog_data_out,
    .prog_data_oe, .i2c_enable, .scl_drive_low, .sda_drive_low, .pin_out_ff, .pin_oe_ff, .pullup_ff,
    .ioc_pulse_ff, .pin_level_ff, .adc_connect_ff, .test_analog_on_ff, .test_analog_sel_ff, .sync_clk_in_ff,
    .ref2_out_en_ff, .t0_ext_clk_ff, .ext_int_ff, .master_clear_n_ff, .capture_in_ff, .prog_data_in_ff,
    .prog_clk_in_ff, .scl_in_ff, .sda_in_ff);
  board_model board (.clk, .pin_out(pin_out_ff), .pin_oe(pin_oe_ff), .pull_on(pullup_ff), .ext_en, .ext_val,
    .pin_in);

  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic test_done();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // converter switches, pull-ups and drivers of pins 0..3
  task automatic t_analog();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      port_a_direction <= 8'hFF;
      analog_select_a <= 4'h1 << i;
      step(1);
      chk({adc_connect_ff, pullup_ff & 9'h1AF}, {4'h1 << i, 9'h02F});
      @(posedge clk);
      port_a_direction[i] <= 1'b0;
      step(1);
      chk({adc_connect_ff, pin_oe_ff[i], pullup_ff[i]}, 6'h02);
    end
    @(posedge clk);
    port_a_direction <= 8'hFF;
  endtask : t_analog

  // debug output on pin 0, digital then analog, then clock enable freeze
  task automatic t_debug();
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      debug_out_en <= 1'b1;
      debug_digital_sel <= k[2:0];
      step(1);
      chk({pin_oe_ff[0], pin_out_ff[0]}, {1'b1, debug_digital_bus[k]});
    end
    @(posedge clk);
    debug_analog_mode <= 1'b1;
    converter_control_0 <= 4'hC;
    step(1);
    chk({pin_oe_ff[0], test_analog_on_ff, test_analog_sel_ff}, 6'h1C);
    @(posedge clk);
    ce <= 1'b0;
    converter_control_0 <= 4'h3;
    step(2);
    chk(test_analog_sel_ff, 4'hC);
    @(posedge clk);
    ce <= 1'b1;
    debug_out_en <= 1'b0;
    debug_analog_mode <= 1'b0;
  endtask : t_debug

  // every master/slave code on pin 1
  task automatic t_sync();
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      master_slave_field <= m[1:0];
      sync_clk_out <= 1'b1;
      ext_en[1] <= 1'b1;
      ext_val[1] <= 1'b1;
      step(5);
      chk({pin_oe_ff[1], pin_oe_ff[1] & pin_out_ff[1], ref2_out_en_ff, sync_clk_in_ff},
          {m == 1, m == 1, m == 1, m == 2});
    end
    @(posedge clk);
    master_slave_field <= 2'h0;
  endtask : t_sync

  // pin 2 as timer clock and interrupt, change pulse timing
  task automatic t_pin2();
    @(posedge clk);
    timer0_source_select <= 1'b1;
    external_interrupt_enable <= 1'b1;
    ext_en[2] <= 1'b1;
    ext_val[2] <= 1'b1;
    step(5);
    chk({t0_ext_clk_ff, ext_int_ff}, 2'h3);
    @(posedge clk);
    ext_val[2] <= 1'b0;
    step(4);
    chk({t0_ext_clk_ff, ext_int_ff, ioc_pulse_ff[2], pin_level_ff[2]}, 4'h2);
    step(1);
    chk(ioc_pulse_ff[2], 1'b0);
    @(posedge clk);
    timer0_source_select <= 1'b0;
    ext_val[2] <= 1'b1;
    step(5);
    chk({t0_ext_clk_ff, ext_int_ff}, 2'h1);
    @(posedge clk);
    external_interrupt_enable <= 1'b0;
  endtask : t_pin2

  // pin 5 input only and master clear
  task automatic t_pin5();
    @(posedge clk);
    port_a_direction[5] <= 1'b0;
    pin_latch[5] <= 1'b1;
    master_clear_enable <= 1'b1;
    ext_en[5] <= 1'b1;
    ext_val[5] <= 1'b0;
    step(5);
    chk({pin_oe_ff[5], master_clear_n_ff, pin_level_ff[5]}, 3'h0);
    @(posedge clk);
    master_clear_enable <= 1'b0;
    ext_val[5] <= 1'b1;
    step(4);
    chk({master_clear_n_ff, ioc_pulse_ff[5]}, 2'h3);
    @(posedge clk);
    port_a_direction[5] <= 1'b1;
  endtask : t_pin5

  // pin 6 compare, capture and programming data priority
  task automatic t_pin6();
    @(posedge clk);
    compare_en <= 1'b1;
    compare_out <= 1'b1;
    step(1);
    chk({pin_oe_ff[6], pin_out_ff[6], capture_in_ff}, 3'h7);
    @(posedge clk);
    prog_mode <= 1'b1;
    ext_en[6] <= 1'b1;
    ext_val[6] <= 1'b1;
    step(5);
    chk({pin_oe_ff[6], prog_data_in_ff, capture_in_ff}, 3'h3);
    @(posedge clk);
    prog_data_oe <= 1'b1;
    step(1);
    chk({pin_oe_ff[6], pin_out_ff[6]}, 2'h2);
    @(posedge clk);
    prog_mode <= 1'b0;
    compare_en <= 1'b0;
  endtask : t_pin6

  // open-drain pins 7 and b0, programming clock, i2c
  task automatic t_drain();
    @(posedge clk);
    port_a_direction[7] <= 1'b0;
    port_b_direction <= 1'b0;
    pin_latch[8:7] <= 2'h3;
    step(1);
    chk({pin_oe_ff[8:7], pin_out_ff[8:7], pullup_ff[8:7]}, 6'h00);
    @(posedge clk);
    pin_latch[8:7] <= 2'h0;
    step(5);
    chk({pin_oe_ff[8:7], pin_out_ff[8:7], prog_clk_in_ff}, 5'h18);
    @(posedge clk);
    pin_latch[8:7] <= 2'h3;
    port_a_direction[7] <= 1'b1;
    port_b_direction <= 1'b1;
    i2c_enable <= 1'b1;
    scl_drive_low <= 1'b1;
    step(5);
    chk({pin_oe_ff[8:7], scl_in_ff, sda_in_ff, prog_clk_in_ff}, 5'h0A);
    @(posedge clk);
    scl_drive_low <= 1'b0;
    sda_drive_low <= 1'b1;
    step(5);
    chk({pin_oe_ff[8:7], scl_in_ff, sda_in_ff, prog_clk_in_ff}, 5'h15);
  endtask : t_drain

  // reset, then every scenario in turn
  initial begin
    step(12);
    chk({pin_oe_ff, pin_level_ff, master_clear_n_ff}, 19'h003FF);
    @(posedge clk);
    rstn <= 1'b1;
    t_analog();
    t_debug();
    t_sync();
    t_pin2();
    t_pin5();
    t_pin6();
    t_drain();
    test_done();
  end
endmodule : testbench
